// ==== rtl/disk_status_bank.sv ====
// chip status and termination bank of a disk controller, avalon-mm slave
// assumes read channel reports arrive as slow levels from another clock
`timescale 1ns/1ps
module disk_status_bank (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [9:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire disk_ctrl_pkg::drive_events_t drive_in,
    input wire logic io_reset,
    output logic irq,
    output logic command_busy,
    output logic [1:0] selected_drive_number
);

    // command sequencer states, one-hot
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_BUSY = 3'b010,
        ST_STOPPING = 3'b100
    } cmd_state_t;

    localparam int SYNC_W = $bits(disk_ctrl_pkg::drive_events_t) + 1;

    // word index; low address bits ignored
    function automatic logic [7:0] word_index(input logic [9:0] byte_addr);
        word_index = byte_addr[9:2];
    endfunction

    // bus slave state
    logic waitrequest_reg; // high except in the answer cycle
    logic [31:0] readdata_reg; // read answer
    logic bus_access; // request taken this edge
    logic bus_wr; // write taken
    logic bus_rd; // read taken
    logic [7:0] bus_idx; // decoded word index
    logic low_lane; // byte lane 0 enabled

    // synchronised pin side
    logic [SYNC_W-1:0] sync_bus; // synchronised bundle
    disk_ctrl_pkg::drive_events_t ev_now; // current synced levels
    disk_ctrl_pkg::drive_events_t ev_prev_reg; // one cycle older copy
    logic io_reset_now; // synced io reset level
    logic io_reset_prev_reg; // for edge detect
    logic retry_p, ecc_att_p, ecc_err_p, id_p, sync_p, sector_p, data_p, io_rst_p;

    // registers seen by software
    disk_ctrl_pkg::chip_status_t chip_status_reg; // flags and drive number
    logic [7:0] termination_reg; // write only
    logic [disk_ctrl_pkg::CYL_W-1:0] desired_cyl_reg; // compare target
    logic [disk_ctrl_pkg::HEAD_W-1:0] desired_head_reg; // compare target
    logic [1:0] drive_select_reg; // chosen drive
    logic done_reg; // completion flag
    logic irq_pending_reg; // completion interrupt pending
    logic [disk_ctrl_pkg::EVENT_COUNT-1:0] event_mask_reg; // interrupt mask
    logic [disk_ctrl_pkg::EVENT_COUNT-1:0] event_set; // one-cycle events
    logic [disk_ctrl_pkg::EVENT_COUNT-1:0] event_status; // sticky view
    logic event_irq; // unmasked sticky bit
    logic irq_reg; // combined interrupt output

    // command sequencer
    cmd_state_t state_reg;
    cmd_state_t state_next;
    logic busy_reg; // registered copy of non-idle state
    logic cmd_write; // any command written
    logic cmd_reset; // reset command written
    logic cmd_start; // ordinary command written
    logic mismatch; // id differs from desired
    logic finish; // command completes this cycle
    logic abort_now; // sync or compare ends command

    // bus decode
    assign bus_access = (avs_read | avs_write) & ~waitrequest_reg;
    assign bus_wr = bus_access & avs_write;
    assign bus_rd = bus_access & avs_read;
    assign bus_idx = word_index(avs_address);
    assign low_lane = avs_byteenable[0];

    // command port write
    assign cmd_write = bus_wr & low_lane & (bus_idx == disk_ctrl_pkg::IDX_COMMAND);
    assign cmd_reset = cmd_write & (avs_writedata[7:0] == disk_ctrl_pkg::CMD_RESET);
    assign cmd_start = cmd_write & ~cmd_reset;

    // one wait cycle, then answer
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            waitrequest_reg <= 1'b1;
        end else begin
            waitrequest_reg <= ~((avs_read | avs_write) & waitrequest_reg);
        end
    end

    // read mux; unmapped and write-only read zero
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            readdata_reg <= 32'h0000_0000;
        end else if (avs_read & waitrequest_reg) begin
            unique case (bus_idx)
                disk_ctrl_pkg::IDX_CHIP_STATUS: readdata_reg <= {24'h00_0000, chip_status_reg};
                disk_ctrl_pkg::IDX_INT_STATUS: begin
                    readdata_reg <= {29'h0, command_busy, irq_pending_reg, done_reg};
                end
                disk_ctrl_pkg::IDX_EVENT_STATUS: readdata_reg <= {28'h0, event_status};
                disk_ctrl_pkg::IDX_EVENT_MASK: readdata_reg <= {28'h0, event_mask_reg};
                disk_ctrl_pkg::IDX_DESIRED_CYL: readdata_reg <= {22'h0, desired_cyl_reg};
                disk_ctrl_pkg::IDX_DESIRED_HEAD: readdata_reg <= {28'h0, desired_head_reg};
                disk_ctrl_pkg::IDX_DRIVE_SELECT: readdata_reg <= {30'h0, drive_select_reg};
                default: readdata_reg <= 32'h0000_0000;
            endcase
        end
    end

    // drive side levels cross into mclk first
    pin_sync #(
        .WIDTH(SYNC_W)
    ) u_sync (
        .mclk(mclk),
        .rst_b(rst_b),
        .async_in({drive_in, io_reset}),
        .sync_out(sync_bus)
    );

    assign ev_now = sync_bus[SYNC_W-1:1];
    assign io_reset_now = sync_bus[0];

    // delayed copy for rising edge detection
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ev_prev_reg <= '0;
            io_reset_prev_reg <= 1'b0;
        end else begin
            ev_prev_reg <= ev_now;
            io_reset_prev_reg <= io_reset_now;
        end
    end

    // one pulse per rising edge
    assign retry_p = ev_now.retry & ~ev_prev_reg.retry;
    assign ecc_att_p = ev_now.ecc_attempt & ~ev_prev_reg.ecc_attempt;
    assign ecc_err_p = ev_now.ecc_error & ~ev_prev_reg.ecc_error;
    assign id_p = ev_now.id_valid & ~ev_prev_reg.id_valid;
    assign sync_p = ev_now.sync_lost & ~ev_prev_reg.sync_lost;
    assign sector_p = ev_now.sector_done & ~ev_prev_reg.sector_done;
    assign data_p = ev_now.data_done & ~ev_prev_reg.data_done;
    assign io_rst_p = io_reset_now & ~io_reset_prev_reg;

    // id field against desired cylinder and head
    assign mismatch = (ev_now.id_cylinder != desired_cyl_reg) |
                      (ev_now.id_head != desired_head_reg);

    assign abort_now = (state_reg != ST_IDLE) & (sync_p | (id_p & mismatch));

    // command sequencer next state
    always_comb begin
        state_next = state_reg;
        finish = 1'b0;
        unique case (state_reg)
            ST_IDLE: begin
                if (cmd_start) begin
                    state_next = ST_BUSY;
                end
            end
            ST_BUSY: begin
                if (abort_now | data_p) begin
                    state_next = ST_IDLE;
                    finish = 1'b1;
                end else if (id_p & ev_now.id_deleted &
                             termination_reg[disk_ctrl_pkg::TERM_STOP_ON_DELETED_MARK]) begin
                    state_next = ST_STOPPING;
                end
            end
            ST_STOPPING: begin
                // sector end, data end or abort
                if (abort_now | sector_p | data_p) begin
                    state_next = ST_IDLE;
                    finish = 1'b1;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
        // reset command abandons work
        if (cmd_reset) begin
            state_next = ST_IDLE;
            finish = 1'b0;
        end
    end

    // sequencer state
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= ST_IDLE;
            busy_reg <= 1'b0;
        end else if (io_rst_p) begin
            state_reg <= ST_IDLE;
            busy_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            busy_reg <= state_next != ST_IDLE;
        end
    end

    // flags freeze once idle
    // flags set only while busy, cleared by a non-reset command write
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            chip_status_reg <= disk_ctrl_pkg::CHIP_STATUS_RESET;
        end else begin
            chip_status_reg.selected_drive_number <= drive_select_reg;
            if (cmd_start) begin
                chip_status_reg.retry_attempted <= 1'b0;
                chip_status_reg.correction_attempted <= 1'b0;
                chip_status_reg.check_code_error <= 1'b0;
                chip_status_reg.deleted_mark_seen <= 1'b0;
                chip_status_reg.sync_missing <= 1'b0;
                chip_status_reg.id_compare_mismatch <= 1'b0;
            end else if (state_reg != ST_IDLE) begin
                if (retry_p) begin
                    chip_status_reg.retry_attempted <= 1'b1;
                end
                if (ecc_att_p) begin
                    chip_status_reg.correction_attempted <= 1'b1;
                end
                if (ecc_err_p) begin
                    chip_status_reg.check_code_error <= 1'b1;
                end
                if (id_p) begin
                    chip_status_reg.deleted_mark_seen <= ev_now.id_deleted;
                end
                if (sync_p) begin
                    chip_status_reg.sync_missing <= 1'b1;
                end
                if (id_p & mismatch) begin
                    chip_status_reg.id_compare_mismatch <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            termination_reg <= disk_ctrl_pkg::TERM_RESET;
        end else if (cmd_reset | io_rst_p) begin
            termination_reg <= disk_ctrl_pkg::TERM_RESET;
        end else if (bus_wr & low_lane & (bus_idx == disk_ctrl_pkg::IDX_TERMINATION)) begin
            termination_reg <= avs_writedata[7:0];
        end
    end

    // software setup; status ignores writes
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            desired_cyl_reg <= '0;
            desired_head_reg <= '0;
            drive_select_reg <= disk_ctrl_pkg::DRIVE_HARD_FIRST;
            event_mask_reg <= disk_ctrl_pkg::EVENT_MASK_RESET;
        end else if (bus_wr) begin
            // cylinder spans two lanes
            if (bus_idx == disk_ctrl_pkg::IDX_DESIRED_CYL) begin
                if (low_lane) begin
                    desired_cyl_reg[7:0] <= avs_writedata[7:0];
                end
                if (avs_byteenable[1]) begin
                    desired_cyl_reg[disk_ctrl_pkg::CYL_W-1:8] <=
                        avs_writedata[disk_ctrl_pkg::CYL_W-1:8];
                end
            end
            if (low_lane) begin
                if (bus_idx == disk_ctrl_pkg::IDX_DESIRED_HEAD) begin
                    desired_head_reg <= avs_writedata[disk_ctrl_pkg::HEAD_W-1:0];
                end
                // code 3 is refused
                if ((bus_idx == disk_ctrl_pkg::IDX_DRIVE_SELECT) & (avs_writedata[1:0] != 2'h3)) begin
                    drive_select_reg <= avs_writedata[1:0];
                end
                if (bus_idx == disk_ctrl_pkg::IDX_EVENT_MASK) begin
                    event_mask_reg <= avs_writedata[disk_ctrl_pkg::EVENT_COUNT-1:0];
                end
            end
        end
    end

    // done and pending; completion beats clear
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            done_reg <= 1'b0;
            irq_pending_reg <= 1'b0;
        end else begin
            if (finish) begin
                done_reg <= 1'b1;
            end else if (cmd_write) begin
                done_reg <= 1'b0;
            end
            if (finish & termination_reg[disk_ctrl_pkg::TERM_IRQ_ON_COMPLETION]) begin
                irq_pending_reg <= 1'b1;
            end else if (cmd_write | io_rst_p |
                         (bus_rd & (bus_idx == disk_ctrl_pkg::IDX_INT_STATUS))) begin
                irq_pending_reg <= 1'b0;
            end
        end
    end

    // events feeding the sticky status
    always_comb begin
        event_set = '0;
        event_set[disk_ctrl_pkg::EV_DONE] = finish;
        event_set[disk_ctrl_pkg::EV_SYNC_MISSING] = abort_now & sync_p;
        event_set[disk_ctrl_pkg::EV_COMPARE] = abort_now & id_p & mismatch;
        event_set[disk_ctrl_pkg::EV_CHECK_CODE] = (state_reg != ST_IDLE) & ecc_err_p;
    end

    event_status #(
        .N(disk_ctrl_pkg::EVENT_COUNT)
    ) u_events (
        .mclk(mclk),
        .rst_b(rst_b),
        .set_vec(event_set),
        .rd_clear(bus_rd & (bus_idx == disk_ctrl_pkg::IDX_EVENT_STATUS)),
        .mask(event_mask_reg),
        .status(event_status),
        .irq_any(event_irq)
    );

    // irq: pending or unmasked event
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= irq_pending_reg | event_irq;
        end
    end

    assign avs_readdata = readdata_reg;
    assign avs_waitrequest = waitrequest_reg;
    assign irq = irq_reg;
    assign command_busy = busy_reg;
    assign selected_drive_number = chip_status_reg.selected_drive_number;

endmodule

// ==== common/disk_ctrl_pkg.sv ====
// constants, field layouts and carriers for the disk controller status bank
// assumes a 32-bit avalon-mm slave with byte addresses, word per register
package disk_ctrl_pkg;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_CHIP_STATUS = 8'h08;
    localparam logic [7:0] IDX_TERMINATION = 8'h09;
    localparam logic [7:0] IDX_COMMAND = 8'h10;
    localparam logic [7:0] IDX_INT_STATUS = 8'h11;
    localparam logic [7:0] IDX_EVENT_STATUS = 8'h12;
    localparam logic [7:0] IDX_EVENT_MASK = 8'h13;
    localparam logic [7:0] IDX_DESIRED_CYL = 8'h14;
    localparam logic [7:0] IDX_DESIRED_HEAD = 8'h15;
    localparam logic [7:0] IDX_DRIVE_SELECT = 8'h16;

    // termination register fields
    localparam int TERM_IRQ_ON_COMPLETION = 5;
    localparam int TERM_STOP_ON_DELETED_MARK = 4;
    localparam logic [7:0] TERM_RESET = 8'h00;

    // interrupt status port fields
    localparam int INT_DONE = 0;
    localparam int INT_IRQ_PENDING = 1;
    localparam int INT_BUSY = 2;

    // event status bits (sticky, read clears)
    localparam int EVENT_COUNT = 4;
    localparam int EV_DONE = 0;
    localparam int EV_SYNC_MISSING = 1;
    localparam int EV_COMPARE = 2;
    localparam int EV_CHECK_CODE = 3;

    // command codes and drive numbers
    localparam logic [7:0] CMD_RESET = 8'h00;
    localparam logic [1:0] DRIVE_HARD_FIRST = 2'h0;
    localparam logic [1:0] DRIVE_HARD_SECOND = 2'h1;
    localparam logic [1:0] DRIVE_DISKETTE = 2'h2;

    // reset values and synchroniser depth
    localparam logic [7:0] CHIP_STATUS_RESET = 8'h00;
    localparam logic [3:0] EVENT_MASK_RESET = 4'h0;
    localparam int SYNC_STAGES = 2;

    // id field widths
    localparam int CYL_W = 10;
    localparam int HEAD_W = 4;

    // chip status layout, bit 7 down to bit 0
    typedef struct packed {
        logic retry_attempted;
        logic correction_attempted;
        logic check_code_error;
        logic deleted_mark_seen;
        logic sync_missing;
        logic id_compare_mismatch;
        logic [1:0] selected_drive_number;
    } chip_status_t;

    // reports coming from the read channel beside the drives
    typedef struct packed {
        logic retry;
        logic ecc_attempt;
        logic ecc_error;
        logic id_valid;
        logic id_deleted;
        logic sync_lost;
        logic sector_done;
        logic data_done;
        logic [CYL_W-1:0] id_cylinder;
        logic [HEAD_W-1:0] id_head;
    } drive_events_t;

endpackage

// ==== rtl/pin_sync.sv ====
// two-flop synchroniser bank for levels arriving from outside mclk
// assumes each input level stands at least two mclk periods
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 8
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_reg; // first stage, read only by second stage
    logic [WIDTH-1:0] sync_reg; // second stage, safe to use

    // two stages, constant reset values
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
        end
    end

    assign sync_out = sync_reg;

endmodule

// ==== rtl/event_status.sv ====
// sticky event bits with mask and one registered interrupt level
// assumes rd_clear is a one-cycle strobe from the bus slave
`timescale 1ns/1ps
module event_status #(
    parameter int N = 4
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [N-1:0] set_vec,
    input wire logic rd_clear,
    input wire logic [N-1:0] mask,
    output logic [N-1:0] status,
    output logic irq_any
);

    logic [N-1:0] status_reg; // sticky bits
    logic irq_reg; // unmasked bit standing

    // set wins over the clear of the same cycle
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            status_reg <= '0;
        end else if (rd_clear) begin
            status_reg <= set_vec;
        end else begin
            status_reg <= status_reg | set_vec;
        end
    end

    // level output, one cycle behind the bits
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(status_reg & mask);
        end
    end

    assign status = status_reg;
    assign irq_any = irq_reg;

endmodule

// ==== bench/disk_ctrl_checker.sv ====
// assertions on the ports of the disk status bank
// assumes one clock domain and the package compiled first
`timescale 1ns/1ps
module disk_ctrl_checker (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [9:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire disk_ctrl_pkg::drive_events_t drive_in,
    input wire logic io_reset,
    input wire logic irq,
    input wire logic command_busy,
    input wire logic [1:0] selected_drive_number
);
    // lane 0 write taken
    wire logic wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
    wire logic [7:0] idx = avs_address[9:2];
    wire logic cmd_wr = wr_ok && idx == disk_ctrl_pkg::IDX_COMMAND;
    wire logic rd_wait = avs_read && avs_waitrequest;
    logic term_irq_reg; // shadow of the completion interrupt enable
    // io reset drops shadow early; design lags
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            term_irq_reg <= 1'b0;
        end else if (io_reset || (cmd_wr && avs_writedata[7:0] == disk_ctrl_pkg::CMD_RESET)) begin
            term_irq_reg <= 1'b0;
        end else if (wr_ok && idx == disk_ctrl_pkg::IDX_TERMINATION) begin
            term_irq_reg <= avs_writedata[disk_ctrl_pkg::TERM_IRQ_ON_COMPLETION];
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    wait_answer_a:
        assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("late answer");
    wait_once_a:
        assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("long answer");
    rdata_hold_a:
        assert property ($stable(avs_readdata) || $past(rd_wait))
        else $error("read data moved");
    drive_code_a:
        assert property (selected_drive_number != 2'h3)
        else $error("drive code 3");
    busy_cause_a:
        assert property ($rose(command_busy) |-> $past(cmd_wr) || $past(cmd_wr, 2))
        else $error("busy without command");
    sync_stop_a:
        assert property (command_busy && $rose(drive_in.sync_lost) |-> ##[1:6] !command_busy)
        else $error("sync loss kept busy");
    ioreset_stop_a:
        assert property ($rose(io_reset) |-> ##[1:6] !command_busy)
        else $error("io reset kept busy");
    done_irq_a:
        assert property ($fell(command_busy) && term_irq_reg |-> ##[0:2] irq)
        else $error("no done irq");
endmodule

bind disk_status_bank disk_ctrl_checker disk_ctrl_checker_inst (.mclk(mclk), .rst_b(rst_b),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .drive_in(drive_in),
    .io_reset(io_reset), .irq(irq), .command_busy(command_busy),
    .selected_drive_number(selected_drive_number));

// ==== bench/drive_model.sv ====
// behavioural drive side: read channel reports as slow levels
// assumes the bench calls one task at a time
`timescale 1ns/1ps
module drive_model (
    input wire logic mclk,
    output disk_ctrl_pkg::drive_events_t drive_in
);
    initial drive_in = '0;
    // one report held four clocks
    task automatic report(input disk_ctrl_pkg::drive_events_t m);
        @(posedge mclk);
        drive_in <= drive_in | m;
        repeat (4) @(posedge mclk);
        drive_in <= drive_in & ~m;
        repeat (4) @(posedge mclk);
    endtask
    // id lines settle before valid
    task automatic id_field(input logic [9:0] cyl, input logic [3:0] head, input logic del);
        @(posedge mclk);
        drive_in.id_cylinder <= cyl;
        drive_in.id_head <= head;
        drive_in.id_deleted <= del;
        repeat (2) @(posedge mclk);
        drive_in.id_valid <= 1'b1;
        repeat (4) @(posedge mclk);
        drive_in.id_valid <= 1'b0;
        repeat (3) @(posedge mclk);
        // released: show the inverse
        drive_in.id_cylinder <= ~cyl;
        drive_in.id_head <= ~head;
        repeat (4) @(posedge mclk);
    endtask
endmodule

// ==== bench/testbench.sv ====
// self-checking bench for the disk status bank and a drive model
// assumes package, design, checker and model compiled first
`timescale 1ns/1ps
`define CHK(got, want) begin checks_done++; if ((got) !== (want)) begin error_cnt++; \
    $display("unexpected at %0t: %h not %h", $time, got, want); end end
module testbench;
    typedef disk_ctrl_pkg::drive_events_t ev_t;
    localparam ev_t RETRY = '{retry: 1'b1, default: '0};
    localparam ev_t ECC_TRY = '{ecc_attempt: 1'b1, default: '0};
    localparam ev_t ECC_ERR = '{ecc_error: 1'b1, default: '0};
    localparam ev_t SYNC = '{sync_lost: 1'b1, default: '0};
    localparam ev_t SECTOR = '{sector_done: 1'b1, default: '0};
    localparam ev_t DATA = '{data_done: 1'b1, default: '0};
    localparam logic [7:0] CS = disk_ctrl_pkg::IDX_CHIP_STATUS,
        IS = disk_ctrl_pkg::IDX_INT_STATUS, TM = disk_ctrl_pkg::IDX_TERMINATION,
        ES = disk_ctrl_pkg::IDX_EVENT_STATUS;
    logic mclk, rst_b, avs_read, avs_write, io_reset, avs_waitrequest, irq, command_busy;
    logic [9:0] avs_address, cyl;
    logic [31:0] avs_writedata, avs_readdata, exp_w, seed_w;
    logic [3:0] avs_byteenable, head;
    logic [1:0] selected_drive_number, drv;
    ev_t drive_in;
    logic [31:0] exp_q[$]; // notes of expected read answers
    int error_cnt, checks_done;
    disk_status_bank disk_status_bank_inst (.mclk(mclk), .rst_b(rst_b),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .drive_in(drive_in),
        .io_reset(io_reset), .irq(irq), .command_busy(command_busy),
        .selected_drive_number(selected_drive_number));
    drive_model drive_model_inst (.mclk(mclk), .drive_in(drive_in));
    // held until waitrequest sampled low
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] d);
        @(posedge mclk);
        avs_address <= {idx, 2'b00};
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        do @(posedge mclk); while (avs_waitrequest !== 1'b0);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        bus(1'b1, idx, d);
    endtask
    task automatic rd(input logic [7:0] idx, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, idx, 32'h0);
    endtask
    // random nonzero command
    task automatic start;
        wr(disk_ctrl_pkg::IDX_COMMAND, {24'h0, 8'($urandom_range(255, 1))});
        repeat (2) @(negedge mclk);
        `CHK(command_busy, 1'b1) // command runs
    endtask
    // bounded wait for idle
    task automatic wait_idle;
        repeat (40) if (command_busy !== 1'b0) @(negedge mclk);
        repeat (2) @(negedge mclk);
        `CHK(command_busy, 1'b0) // command ended
    endtask
    task automatic end_of_test;
        $display("checks_done %0d error_cnt %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    // oldest note against each answer
    always @(posedge mclk) begin
        if (avs_read && avs_waitrequest === 1'b0) begin
            exp_w = exp_q.pop_front();
            `CHK(avs_readdata, exp_w) // read answer
        end
    end
    // hang guard; run needs ~300 clocks
    initial begin
        #50000;
        error_cnt++;
        $display("unexpected at %0t: timeout", $time);
        end_of_test();
    end
    initial begin
        {rst_b, avs_read, avs_write, io_reset, avs_address, avs_writedata} = '0;
        avs_byteenable = 4'hf;
        seed_w = $urandom(32'ha4fe7f34);
        repeat (12) @(posedge mclk);
        rst_b <= 1'b1;
        rd(CS, 32'h0); // reset value
        wr(CS, 32'hff);
        rd(CS, 32'h0); // write ignored
        rd(TM, 32'h0); // write only
        rd(8'h3f, 32'h0); // unmapped reads zero
        // each drive code; 3 ignored
        for (int i = 0; i < 4; i++) begin
            wr(disk_ctrl_pkg::IDX_DRIVE_SELECT, 32'(i));
            drv = (i == 3) ? 2'h2 : 2'(i);
            rd(CS, {30'h0, drv}); // drive code
            `CHK(selected_drive_number, drv) // drive output
        end
        drv = 2'($urandom_range(2, 0));
        cyl = 10'($urandom_range(1023, 0));
        head = 4'($urandom_range(15, 0));
        wr(disk_ctrl_pkg::IDX_DRIVE_SELECT, {30'h0, drv});
        wr(disk_ctrl_pkg::IDX_DESIRED_CYL, {22'h0, cyl});
        wr(disk_ctrl_pkg::IDX_DESIRED_HEAD, {28'h0, head});
        wr(TM, 32'h20);
        // retry, correction, check code
        start();
        drive_model_inst.report(RETRY);
        drive_model_inst.report(ECC_TRY);
        drive_model_inst.report(ECC_ERR);
        drive_model_inst.id_field(cyl, head, 1'b0);
        drive_model_inst.report(DATA);
        wait_idle();
        `CHK(irq, 1'b1) // completion irq
        rd(CS, {24'h0, 6'b111000, drv}); // flags 7..5
        rd(IS, 32'h3); // done and pending
        rd(ES, 32'h9); // events seen
        repeat (2) @(negedge mclk);
        `CHK(irq, 1'b0) // masked events stay quiet
        // id mismatch ends command
        wr(TM, 32'h0);
        wr(disk_ctrl_pkg::IDX_EVENT_MASK, 32'h4);
        start();
        drive_model_inst.id_field(cyl + 10'h1, head, 1'b0);
        wait_idle();
        `CHK(irq, 1'b1) // unmasked compare event
        rd(CS, {24'h0, 6'b000001, drv}); // old flags gone
        rd(IS, 32'h1); // no pending
        rd(ES, 32'h5); // compare event
        // missing sync ends command
        start();
        drive_model_inst.report(SYNC);
        wait_idle();
        rd(CS, {24'h0, 6'b000010, drv}); // sync flag
        // deleted mark stops after sector
        wr(TM, 32'h10);
        start();
        drive_model_inst.id_field(cyl, head, 1'b1);
        @(negedge mclk);
        `CHK(command_busy, 1'b1) // sector still runs
        drive_model_inst.report(SECTOR);
        wait_idle();
        rd(CS, {24'h0, 6'b000100, drv}); // deleted flag
        // io reset aborts, drops irq enable
        wr(TM, 32'h20);
        start();
        @(posedge mclk);
        io_reset <= 1'b1;
        repeat (4) @(posedge mclk);
        io_reset <= 1'b0;
        wait_idle();
        rd(IS, 32'h0); // ended without done
        start();
        drive_model_inst.report(DATA);
        wait_idle();
        rd(IS, 32'h1); // enable cleared
        repeat (4) @(posedge mclk);
        end_of_test();
    end
endmodule
